// >>> src/uts_defs.svh
/*
 Register offsets, field positions, a write mask, reset values and the endpoint count for the
 transaction status and device-mode control block.
 Assumes a 16-bit register port with word indices; included by its bare name.
*/
`ifndef UTS_DEFS_SVH
`define UTS_DEFS_SVH

`define UTS_ADDR_STATUS 3'h0
`define UTS_ADDR_CONTROL 3'h1
`define UTS_ADDR_POWER 3'h2
`define UTS_ADDR_OTG 3'h3
`define UTS_ADDR_IRQ_STAT 3'h4
`define UTS_ADDR_IRQ_MASK 3'h5

`define UTS_STAT_EP_HI 7
`define UTS_STAT_EP_LO 4
`define UTS_STAT_DIR 3
`define UTS_STAT_BANK 2

`define UTS_CON_SE0 6
`define UTS_CON_PKTOFF 5
`define UTS_CON_HOST 3
`define UTS_CON_RESUME 2
`define UTS_CON_PPRST 1
`define UTS_CON_MODEN 0
`define UTS_CON_WMASK 16'h002f

`define UTS_PWR_EN 0
`define UTS_OTG_EN 2

`define UTS_IRQ_DONE 0
`define UTS_IRQ_PWRERR 1
`define UTS_IRQ_BITS 2

`define UTS_STATUS_RESET 16'h0000
`define UTS_CONTROL_RESET 16'h0000

`define UTS_NUM_EP 16

`endif

// >>> src/uts_pkg.sv
/*
 Types shared by the transaction status and control block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package uts_pkg;
    typedef logic [15:0] uts_word_t;
    typedef logic [3:0] uts_ep_t;
    typedef logic [2:0] uts_addr_t;
    typedef enum logic [2:0] {
        UTS_OFF = 3'b001,
        UTS_DEVICE = 3'b010,
        UTS_HOST = 3'b100
    } uts_mode_t;
endpackage

// >>> src/uts_pingpong.sv
/*
 One ping-pong bank pointer per endpoint direction: toggles on each
 completed transaction, forced back to even on a pointer reset.
 Assumes one clock and an asynchronous active-high reset.
*/
`timescale 1ns/100ps
module uts_pingpong (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control
    input wire logic toggle,
    input wire logic clear,
    // State
    output logic odd
);
    import uts_pkg::*;

    logic odd_ff;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            odd_ff <= 1'b0;
        end else if (clear) begin
            odd_ff <= 1'b0;
        end else if (toggle) begin
            odd_ff <= ~odd_ff;
        end
    end

    assign odd = odd_ff;
endmodule

// >>> src/uts_top.sv
/*
 Transaction status and device-mode control registers of a USB serial
 interface engine, with a small interrupt block.
 Assumes the engine pulses xact_done with endpoint and direction on the
 same cycle, and that software uses a one-cycle-latency register port.
*/
// Local design decisions: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
`include "uts_defs.svh"
module uts_top (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire uts_pkg::uts_addr_t reg_addr,
    input wire uts_pkg::uts_word_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output uts_pkg::uts_word_t reg_rdata,
    // Engine side
    input wire logic xact_done,
    input wire uts_pkg::uts_ep_t xact_ep,
    input wire logic xact_tx,
    input wire logic bus_se0,
    output logic [`UTS_NUM_EP*2-1:0] pp_odd,
    output logic pp_reset,
    // Module controls
    output logic module_on,
    output logic host_on,
    output logic device_on,
    output logic resume_on,
    output logic pkt_disable,
    output uts_pkg::uts_mode_t mode,
    // Interrupt
    output logic irq
);
    import uts_pkg::*;

    uts_word_t status_ff;
    logic [5:0] con_ff;
    logic pwr_ff;
    logic otg_ff;
    logic [`UTS_IRQ_BITS-1:0] ist_ff;
    logic [`UTS_IRQ_BITS-1:0] imask_ff;
    uts_word_t rdata_ff;
    uts_word_t nxt_rdata;
    uts_mode_t mode_ff;
    uts_mode_t nxt_mode;
    logic pprst_pulse_ff;
    logic bank_now;
    logic [3:0] ep_rec;
    logic pwr_error;
    logic [`UTS_IRQ_BITS-1:0] ev;
    logic [4:0] pp_idx;

    wire wr_con = reg_wr && reg_addr == `UTS_ADDR_CONTROL;
    wire wr_pwr = reg_wr && reg_addr == `UTS_ADDR_POWER;
    wire wr_otg = reg_wr && reg_addr == `UTS_ADDR_OTG;
    wire wr_mask = reg_wr && reg_addr == `UTS_ADDR_IRQ_MASK;
    wire rd_ist = reg_rd && reg_addr == `UTS_ADDR_IRQ_STAT;
    wire pprst_req = wr_con && reg_wdata[`UTS_CON_PPRST];

    // Per endpoint and direction pointer; index = {ep, tx}
    genvar gi;
    generate
        for (gi = 0; gi < `UTS_NUM_EP * 2; gi++) begin : g_pp
            uts_pingpong u_pp (
                .clk(clk),
                .rst(rst),
                .toggle(xact_done && module_on && pp_idx == 5'(gi)),
                .clear(pprst_pulse_ff),
                .odd(pp_odd[gi])
            );
        end
    endgenerate

    // Bank used by the finishing transaction is the pointer before its toggle;
    // every pointer here has both banks, so the indicator always carries meaning
    assign bank_now = pp_odd[pp_idx];
    // Host traffic always goes through endpoint zero and its pointers
    assign ep_rec = (mode_ff == UTS_HOST) ? 4'h0 : xact_ep;
    assign pp_idx = {ep_rec, xact_tx};

    // One coherent record per transaction; low and high bits stay zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            status_ff <= `UTS_STATUS_RESET;
        end else if (xact_done && module_on) begin
            status_ff <= {8'h00, ep_rec, xact_tx, bank_now, 2'b00};
        end
    end

    // Control: writable bits only; pointer reset self-clears after one cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            con_ff <= 6'h00;
        end else if (wr_con) begin
            con_ff <= reg_wdata[5:0] & 6'(`UTS_CON_WMASK);
        end else begin
            con_ff[`UTS_CON_PPRST] <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pprst_pulse_ff <= 1'b0;
        end else begin
            pprst_pulse_ff <= pprst_req;
        end
    end

    // Power enable and OTG enable; clearing power too early is flagged
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pwr_ff <= 1'b0;
            otg_ff <= 1'b0;
        end else begin
            if (wr_pwr) begin
                pwr_ff <= reg_wdata[`UTS_PWR_EN];
            end
            if (wr_otg) begin
                otg_ff <= reg_wdata[`UTS_OTG_EN];
            end
        end
    end

    // Not blocked: software owns the order, hardware only reports a breach
    assign pwr_error = wr_pwr && !reg_wdata[`UTS_PWR_EN] && pwr_ff &&
                       (con_ff[`UTS_CON_HOST] || con_ff[`UTS_CON_MODEN] || otg_ff);

    always_comb begin
        nxt_mode = UTS_OFF;
        case (1'b1)
            !pwr_ff: nxt_mode = UTS_OFF;
            con_ff[`UTS_CON_HOST]: nxt_mode = UTS_HOST;
            default: nxt_mode = UTS_DEVICE;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode_ff <= UTS_OFF;
        end else begin
            mode_ff <= nxt_mode;
        end
    end

    assign module_on = pwr_ff;
    assign host_on = pwr_ff && con_ff[`UTS_CON_HOST];
    assign device_on = pwr_ff && con_ff[`UTS_CON_MODEN];
    assign resume_on = con_ff[`UTS_CON_RESUME];
    assign pkt_disable = con_ff[`UTS_CON_PKTOFF];
    assign pp_reset = pprst_pulse_ff;
    assign mode = mode_ff;

    // Interrupts: set wins over the clear-on-read
    assign ev = {pwr_error, xact_done && module_on};

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ist_ff <= '0;
            imask_ff <= '0;
        end else begin
            ist_ff <= (rd_ist ? '0 : ist_ff) | ev;
            if (wr_mask) begin
                imask_ff <= reg_wdata[`UTS_IRQ_BITS-1:0];
            end
        end
    end

    assign irq = |(ist_ff & imask_ff);

    // Read mux; the SE0 flag is live, not stored
    always_comb begin
        nxt_rdata = 16'h0000;
        case (reg_addr)
            `UTS_ADDR_STATUS: nxt_rdata = status_ff;
            `UTS_ADDR_CONTROL: nxt_rdata = {9'h000, bus_se0, con_ff[5], 1'b0, con_ff[3:0]};
            `UTS_ADDR_POWER: nxt_rdata = {15'h0000, pwr_ff};
            `UTS_ADDR_OTG: nxt_rdata = {13'h0000, otg_ff, 2'b00};
            `UTS_ADDR_IRQ_STAT: nxt_rdata = {14'h0000, ist_ff};
            `UTS_ADDR_IRQ_MASK: nxt_rdata = {14'h0000, imask_ff};
            default: nxt_rdata = 16'h0000;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_ff <= 16'h0000;
        end else if (reg_rd) begin
            rdata_ff <= nxt_rdata;
        end else begin
            rdata_ff <= 16'h0000;
        end
    end

    assign reg_rdata = rdata_ff;

    sequence s_done_dev;
        xact_done && module_on && mode_ff != UTS_HOST;
    endsequence

    sequence s_done_on;
        xact_done && module_on;
    endsequence

    // A pointer reset in the same cycle would hide the toggle
    sequence s_done_kept;
        xact_done && module_on && !pp_reset;
    endsequence

    sequence s_done_off;
        xact_done && !module_on && !pp_reset;
    endsequence

    sequence s_pprst_write;
        pprst_req;
    endsequence

    sequence s_read_status;
        reg_rd && reg_addr == `UTS_ADDR_STATUS;
    endsequence

    sequence s_read_control;
        reg_rd && reg_addr == `UTS_ADDR_CONTROL;
    endsequence

    chk_status_ep_record: assert property (@(posedge clk) disable iff (rst)
        s_done_dev |=> status_ff[7:4] == $past(xact_ep))
        else $error("endpoint field not recorded");
    chk_status_dir_bit: assert property (@(posedge clk) disable iff (rst)
        xact_done && module_on |=> status_ff[3] == $past(xact_tx))
        else $error("direction bit wrong");
    chk_status_bank_bit: assert property (@(posedge clk) disable iff (rst)
        xact_done && module_on |=> status_ff[2] == $past(bank_now))
        else $error("bank bit wrong");
    chk_host_ep_zero: assert property (@(posedge clk) disable iff (rst)
        xact_done && module_on && mode_ff == UTS_HOST |=> status_ff[7:4] == 4'h0)
        else $error("host endpoint not zero");
    chk_status_zero_bits: assert property (@(posedge clk) disable iff (rst)
        status_ff[15:8] == 8'h00 && status_ff[1:0] == 2'b00)
        else $error("reserved status bits set");
    chk_status_stable: assert property (@(posedge clk) disable iff (rst)
        !(xact_done && module_on) |=> $stable(status_ff))
        else $error("status changed without transaction");
    chk_pprst_even: assert property (@(posedge clk) disable iff (rst)
        s_pprst_write |=> pp_reset ##1 pp_odd == '0)
        else $error("pointers not reset to even");
    chk_se0_live: assert property (@(posedge clk) disable iff (rst)
        reg_rd && reg_addr == `UTS_ADDR_CONTROL |=> reg_rdata[`UTS_CON_SE0] == $past(bus_se0))
        else $error("se0 flag not live");
    chk_power_enable: assert property (@(posedge clk) disable iff (rst)
        wr_pwr |=> module_on == $past(reg_wdata[`UTS_PWR_EN]) ##1 mode_ff != UTS_OFF || !module_on)
        else $error("power enable not applied");
    chk_pprst_source: assert property (@(posedge clk) disable iff (rst)
        pp_reset |-> $past(pprst_req))
        else $error("pointer reset pulse without request");
    chk_pprst_selfclear: assert property (@(posedge clk) disable iff (rst)
        con_ff[`UTS_CON_PPRST] && !wr_con |=> !con_ff[`UTS_CON_PPRST])
        else $error("pointer reset bit did not clear");
    chk_pp_toggle: assert property (@(posedge clk) disable iff (rst)
        s_done_kept |=> pp_odd[$past(pp_idx)] != $past(bank_now))
        else $error("bank pointer did not toggle");
    chk_off_ignored: assert property (@(posedge clk) disable iff (rst)
        s_done_off |=> $stable(status_ff) && $stable(pp_odd))
        else $error("transaction taken while disabled");
    chk_status_read: assert property (@(posedge clk) disable iff (rst)
        s_read_status |=> reg_rdata == $past(status_ff))
        else $error("status read data wrong");
    chk_control_fixed: assert property (@(posedge clk) disable iff (rst)
        s_read_control |=> reg_rdata[15:7] == 9'h000 && reg_rdata[4] == 1'b0)
        else $error("fixed control bits not zero");
    chk_rdata_idle: assert property (@(posedge clk) disable iff (rst)
        !reg_rd |=> reg_rdata == 16'h0000)
        else $error("read data without read");
    chk_irq_done_set: assert property (@(posedge clk) disable iff (rst)
        s_done_on |=> ist_ff[`UTS_IRQ_DONE])
        else $error("done flag not set");
    chk_irq_read_clear: assert property (@(posedge clk) disable iff (rst)
        rd_ist && !ev[`UTS_IRQ_DONE] |=> !ist_ff[`UTS_IRQ_DONE])
        else $error("done flag not cleared by read");
    chk_irq_breach: assert property (@(posedge clk) disable iff (rst)
        pwr_error |=> ist_ff[`UTS_IRQ_PWRERR])
        else $error("power order breach not flagged");
    chk_mode_off: assert property (@(posedge clk) disable iff (rst)
        !pwr_ff |=> mode == UTS_OFF)
        else $error("mode not off while disabled");
    chk_mode_host: assert property (@(posedge clk) disable iff (rst)
        pwr_ff && con_ff[`UTS_CON_HOST] |=> mode == UTS_HOST)
        else $error("mode not host");
endmodule

// >>> testbench/uts_bus_model.sv
/*
 Far-side bus model: replays one completed transaction per request.
 Assumes requests arrive from the bench just after a rising edge.
*/
`timescale 1ns/100ps
module uts_bus_model (
    // Clock
    input wire logic clk,
    // Bench requests
    input wire logic send,
    input wire logic [3:0] ep_in,
    input wire logic tx_in,
    input wire logic se0_in,
    // Engine side
    output logic xact_done,
    output logic [3:0] xact_ep,
    output logic xact_tx,
    output logic bus_se0
);
    logic done_ff = 1'b0;
    logic [3:0] ep_ff = 4'h0;
    logic tx_ff = 1'b0;
    // Idle fields flip each cycle so stale values are never mistaken for a record
    always_ff @(posedge clk) begin
        done_ff <= send;
        ep_ff <= send ? ep_in : ~ep_ff;
        tx_ff <= send ? tx_in : ~tx_ff;
    end
    assign xact_done = done_ff;
    assign xact_ep = ep_ff;
    assign xact_tx = tx_ff;
    assign bus_se0 = se0_in;
endmodule

// >>> testbench/tb.sv
/*
 Self-checking bench for the transaction status and control block.
 Assumes the word-indexed register map and one-cycle read latency of the block.
*/
`timescale 1ns/100ps
`include "uts_defs.svh"
module tb;
    import uts_pkg::*;
    logic clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic send = 1'b0, tx_in = 1'b0, se0_in = 1'b0;
    logic [3:0] ep_in = 4'h0;
    uts_addr_t reg_addr = 3'h0;
    uts_word_t reg_wdata = 16'h0000, reg_rdata, last;
    logic xact_done, xact_tx, bus_se0, pp_reset, module_on, host_on, device_on, irq;
    logic resume_on, pkt_disable;
    uts_ep_t xact_ep;
    logic [31:0] pp_odd, pp_exp;
    uts_mode_t mode;
    int err_total = 0, tests_run = 0;
    always #2.5 clk = ~clk;
    uts_bus_model uts_bus_model_inst (.clk(clk), .send(send), .ep_in(ep_in), .tx_in(tx_in),
        .se0_in(se0_in), .xact_done(xact_done), .xact_ep(xact_ep), .xact_tx(xact_tx), .bus_se0(bus_se0));
    uts_top uts_top_inst (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .xact_done(xact_done),
        .xact_ep(xact_ep), .xact_tx(xact_tx), .bus_se0(bus_se0), .pp_odd(pp_odd),
        .pp_reset(pp_reset), .module_on(module_on), .host_on(host_on), .device_on(device_on),
        .resume_on(resume_on), .pkt_disable(pkt_disable), .mode(mode), .irq(irq));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input uts_addr_t a, input uts_word_t d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input uts_addr_t a, input uts_word_t exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk({16'h0, reg_rdata}, {16'h0, exp});
    endtask
    // Expected bank is the pointer before its toggle
    task automatic xact(input logic [3:0] ep, input logic tx, input logic on);
        @(posedge clk);
        send <= 1'b1;
        ep_in <= ep;
        tx_in <= tx;
        @(posedge clk);
        send <= 1'b0;
        repeat (2) @(posedge clk);
        if (on) begin
            last = {8'h00, ep, tx, pp_exp[{ep, tx}], 2'b00};
            pp_exp[{ep, tx}] = ~pp_exp[{ep, tx}];
        end
    endtask
    task automatic t_power_on;
        rd(`UTS_ADDR_STATUS, 16'h0000);
        wr(`UTS_ADDR_POWER, 16'h0001);
        wr(`UTS_ADDR_CONTROL, 16'h0001);
        #1 chk({module_on, device_on, host_on}, 3'b110);
        chk(mode, UTS_DEVICE);
    endtask
    task automatic t_xacts;
        for (int i = 0; i < 34; i++) begin
            xact(i[3:0], i[4], 1'b1);
            rd(`UTS_ADDR_STATUS, last);
        end
        xact(4'hf, 1'b1, 1'b1);
        xact(4'h6, 1'b0, 1'b1);
        rd(`UTS_ADDR_STATUS, last);
        chk(pp_odd, pp_exp);
        wr(`UTS_ADDR_STATUS, 16'hffff);
        rd(`UTS_ADDR_STATUS, last);
        rd(3'h7, 16'h0000);
    endtask
    task automatic t_host;
        wr(`UTS_ADDR_CONTROL, 16'h0009);
        xact(4'h9, 1'b1, 1'b0);
        // Host traffic goes through endpoint zero and its transmit pointer
        last = {8'h00, 4'h0, 1'b1, pp_exp[1], 2'b00};
        pp_exp[1] = ~pp_exp[1];
        rd(`UTS_ADDR_STATUS, last);
        chk(pp_odd, pp_exp);
        chk({host_on, device_on}, 2'b11);
        chk(mode, UTS_HOST);
    endtask
    task automatic t_ppreset;
        int n;
        wr(`UTS_ADDR_CONTROL, 16'h0003);
        n = 0;
        #1;
        while (pp_reset !== 1'b1 && n < 4) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(n, 0);
        @(posedge clk);
        #1 chk(pp_odd, 32'h0);
        chk(pp_reset, 1'b0);
        pp_exp = 32'h0;
        rd(`UTS_ADDR_CONTROL, 16'h0001);
        @(posedge clk);
        se0_in <= 1'b1;
        rd(`UTS_ADDR_CONTROL, 16'h0041);
        @(posedge clk);
        se0_in <= 1'b0;
        rd(`UTS_ADDR_CONTROL, 16'h0001);
    endtask
    task automatic t_irq;
        rd(`UTS_ADDR_IRQ_STAT, 16'h0001);
        wr(`UTS_ADDR_IRQ_MASK, 16'h0001);
        #1 chk(irq, 1'b0);
        xact(4'h4, 1'b0, 1'b1);
        chk(irq, 1'b1);
        rd(`UTS_ADDR_IRQ_STAT, 16'h0001);
        chk(irq, 1'b0);
    endtask
    task automatic t_power_off;
        wr(`UTS_ADDR_CONTROL, 16'hfff5);
        rd(`UTS_ADDR_CONTROL, 16'h0025);
        chk({pkt_disable, resume_on}, 2'b11);
        wr(`UTS_ADDR_CONTROL, 16'h0000);
        wr(`UTS_ADDR_POWER, 16'h0000);
        #1 chk(module_on, 1'b0);
        xact(4'h2, 1'b1, 1'b0);
        rd(`UTS_ADDR_STATUS, last);
        rd(`UTS_ADDR_IRQ_STAT, 16'h0000);
        chk(mode, UTS_OFF);
    endtask
    // Deliberate out-of-order power-down: the block must flag it, not block it
    task automatic t_breach;
        wr(`UTS_ADDR_POWER, 16'h0001);
        wr(`UTS_ADDR_OTG, 16'h0004);
        rd(`UTS_ADDR_OTG, 16'h0004);
        wr(`UTS_ADDR_POWER, 16'h0000);
        #1 chk(module_on, 1'b0);
        chk(irq, 1'b0);
        rd(`UTS_ADDR_IRQ_STAT, 16'h0002);
        wr(`UTS_ADDR_OTG, 16'h0000);
        rd(`UTS_ADDR_OTG, 16'h0000);
    endtask
    task automatic end_sim;
        if (err_total == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        pp_exp = 32'h0;
        last = 16'h0000;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        t_power_on();
        t_xacts();
        t_host();
        t_ppreset();
        t_irq();
        t_power_off();
        t_breach();
        end_sim();
    end
endmodule
